//--- rsp_regs.svh
// Register offsets, reset values and timing constants of the remote signal preprocessor
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSP_ADDR_CTRL_A   12'hFE8
`define RSP_ADDR_CTRL_B   12'hFE9
`define RSP_ADDR_CAPTURE  12'hFEA
`define RSP_ADDR_DATA     12'hFEB
`define RSP_ADDR_STATUS   12'hFEC

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RSP_CTRL_RESET    8'h00
`define RSP_BYTE_ZERO     8'h00
`define RSP_CNT_MAX       8'hFF
`define RSP_CNT_ONE       8'h01
`define RSP_BITS_ZERO     4'h0
`define RSP_BITS_FIRST    4'h1
`define RSP_BITS_FULL     4'h8
`define RSP_STAT_PAD      3'h0
`define RSP_NOISE_OFF     3'h0
`define RSP_NOISE_MULT    15'h0007
`define RSP_NOISE_ONE     15'h0001
`define RSP_NOISE_ZERO    15'h0000
`define RSP_PRE_ZERO      12'h000
`define RSP_PRE_ONE       12'h001

`endif

//--- rsp_pkg.sv
// Types shared by the remote signal preprocessor files
package rsp_pkg;

    // ----------------------------------------------------------------
    // Modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RSP_SRC_RISE = 2'b00,
        RSP_SRC_FALL = 2'b01,
        RSP_SRC_BOTH = 2'b10,
        RSP_SRC_RECV = 2'b11
    } rsp_src_t;

    typedef enum logic [1:0] {
        RSP_MODE_CYCLE = 2'b00,
        RSP_MODE_WID_A = 2'b01,
        RSP_MODE_WID_B = 2'b10,
        RSP_MODE_WID_C = 2'b11
    } rsp_mode_t;

    // ----------------------------------------------------------------
    // Register layouts and bus carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clk_sel;
        logic       pol;
        rsp_src_t   src;
        logic [2:0] noise;
    } rsp_ctrl_a_t;

    typedef struct packed {
        logic [3:0] thr;
        logic       start;
        logic       enable;
        rsp_mode_t  mode;
    } rsp_ctrl_b_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } rsp_bus_req_t;

endpackage

//--- rsp_sync.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
module rsp_sync
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      sync_o
);
    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
            sync_o  <= 1'b0;
        end
        else
        begin
            ff1_reg <= pin_i;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            if (ff2_reg == ff3_reg)
                sync_o <= ff3_reg;
        end
    end
endmodule

//--- rsp_noise_filter.sv
// Noise canceller: a level change passes only after it has held 7 x 2^k clocks
`timescale 1ns/1ps
`include "rsp_regs.svh"
module rsp_noise_filter
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sig_i,
    input  wire logic [2:0] code_i,
    output logic            sig_o
);
    logic [14:0] cnt_reg;
    logic [14:0] limit;
    logic [3:0]  k_sel;

    always_comb
    begin
        case (code_i)
            3'h1:    k_sel = 4'h2;
            3'h2:    k_sel = 4'h5;
            3'h3:    k_sel = 4'h6;
            3'h4:    k_sel = 4'h7;
            3'h5:    k_sel = 4'h8;
            3'h6:    k_sel = 4'hA;
            3'h7:    k_sel = 4'hB;
            default: k_sel = 4'h0;
        endcase
    end

    // Pulses of up to 7*2^k-1 clocks die; 2^(k+3)+5 always clears the limit
    assign limit = `RSP_NOISE_MULT << k_sel;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= `RSP_NOISE_ZERO;
            sig_o   <= 1'b0;
        end
        else if (code_i == `RSP_NOISE_OFF || sig_i == sig_o)
        begin
            cnt_reg <= `RSP_NOISE_ZERO;
            sig_o   <= sig_i;
        end
        else if (cnt_reg == limit - `RSP_NOISE_ONE)
        begin
            cnt_reg <= `RSP_NOISE_ZERO;
            sig_o   <= sig_i;
        end
        else
            cnt_reg <= cnt_reg + `RSP_NOISE_ONE;
    end
endmodule

//--- rsp_top.sv
// Remote signal preprocessor: filter, width counter, bit decoder and register file
//
// Operation
// - Counter clock is fc divided by 64, 256, 1024 or 4096.
// - Polarity bit inverts the filtered input before every edge and bit decision.
// - Source field picks rising, falling, both edges or eight-bit receive end.
// - Noise code zero bypasses; others reject pulses up to 7*2^k-1 clocks.
// - Filter passes pulses of at least 2^(k+3)+5 clocks.
// - Start bit zero stops and clears counter; one starts counting.
// - Enable bit switches the counter, capture and bit decoder off or on; edge interrupts stay live.
// - Both-edge source ignores measurement mode, measuring low and high widths apart.
// - Edge modes capture counter, clear it, request interrupt, keep counting.
// - Counter at FF requests interrupt, sets overflow flag, clears, halts until restart.
// - Writing start bit one clears the overflow flag.
// - Bit is one when counter upper nibble reaches threshold, else zero.
// - Receive-end mode interrupts after eight decoded bits.
// - Each bit decision copies the counter into the capture register.
// - Decoded bits shift into the data buffer on the active rising edge.
// - Bit count shows stored bits, reloading to one after an interrupt.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "rsp_regs.svh"
module rsp_top
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire rsp_pkg::rsp_bus_req_t  bus_i,
    input  wire logic                   remote_signal_input_i,
    output logic [7:0]                  rd_data_o,
    output logic                        remote_interrupt_request_o
);
    import rsp_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    rsp_ctrl_a_t ctrl_a_reg;
    rsp_ctrl_b_t ctrl_b_reg;
    logic [11:0] pre_reg;
    logic [7:0]  cnt_reg;
    logic        run_reg;
    logic        ovf_reg;
    logic [7:0]  capt_reg;
    logic [7:0]  data_reg;
    logic [3:0]  bits_reg;
    logic        pend_reg;
    logic        sig_prev_reg;

    logic        pin_sync;
    logic        pin_filt;
    rsp_ctrl_b_t wr_b_val;
    logic        wr_a;
    logic        wr_b;
    logic        start_wr;
    logic        stop_wr;
    logic        sig;
    logic        rise;
    logic        fall;
    logic        tick;
    logic        active;
    logic        recv;
    logic        edge_end;
    logic        dec_edge;
    logic        meas_end;
    logic        cnt_clr;
    logic        ovf_hit;
    logic        bit_val;
    logic        shift_now;
    logic        shift_bit;
    logic [3:0]  bits_next;
    logic        irq_next;
    logic [7:0]  rd_next;
    logic [7:0]  status;

    // ----------------------------------------------------------------
    // Input path
    // ----------------------------------------------------------------
    rsp_sync u_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (remote_signal_input_i),
        .sync_o  (pin_sync)
    );

    rsp_noise_filter u_filter
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .sig_i   (pin_sync),
        .code_i  (ctrl_a_reg.noise),
        .sig_o   (pin_filt)
    );

    assign sig  = pin_filt ^ ctrl_a_reg.pol;
    assign rise = sig & ~sig_prev_reg;
    assign fall = ~sig & sig_prev_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign wr_a     = bus_i.we && bus_i.addr == `RSP_ADDR_CTRL_A;
    assign wr_b     = bus_i.we && bus_i.addr == `RSP_ADDR_CTRL_B;
    assign wr_b_val = rsp_ctrl_b_t'(bus_i.wdata);
    assign start_wr = wr_b && wr_b_val.start;
    assign stop_wr  = wr_b && !wr_b_val.start;

    // ----------------------------------------------------------------
    // Prescaler and event selection
    // ----------------------------------------------------------------
    // Free-running divider; all four taps share it, so a select change
    // takes effect at the next tap boundary without a glitch tick
    assign tick = (ctrl_a_reg.clk_sel == 2'h0) ? &pre_reg[5:0]  :
                  (ctrl_a_reg.clk_sel == 2'h1) ? &pre_reg[7:0]  :
                  (ctrl_a_reg.clk_sel == 2'h2) ? &pre_reg[9:0]  :
                                                 &pre_reg[11:0];

    assign active = ctrl_b_reg.enable && run_reg;
    assign recv   = ctrl_a_reg.src == RSP_SRC_RECV;

    // Both-edge source never looks at the mode field
    assign edge_end = (ctrl_a_reg.src == RSP_SRC_RISE) ? rise :
                      (ctrl_a_reg.src == RSP_SRC_FALL) ? fall :
                      (rise | fall);

    // Cycle mode decides on the rising edge, width modes on the falling one
    assign dec_edge = (ctrl_b_reg.mode == RSP_MODE_CYCLE) ? rise : fall;
    assign meas_end = recv ? dec_edge : edge_end;
    // Width modes restart at the rise too, else a fall would see the whole period
    assign cnt_clr  = meas_end || shift_now;
    assign ovf_hit  = active && cnt_reg == `RSP_CNT_MAX && !cnt_clr;

    // Nibble compare equals counter against 16 * threshold ticks
    assign bit_val   = cnt_reg[7:4] >= ctrl_b_reg.thr;
    assign shift_now = recv && rise && active;
    assign shift_bit = (ctrl_b_reg.mode == RSP_MODE_CYCLE) ? bit_val : pend_reg;
    assign bits_next = (bits_reg == `RSP_BITS_FULL) ? `RSP_BITS_FIRST :
                       bits_reg + `RSP_BITS_FIRST;

    // Edge sources stay live when the counter is off: plain external interrupt
    assign irq_next = (!recv && edge_end) ||
                      (shift_now && bits_next == `RSP_BITS_FULL) ||
                      ovf_hit;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    assign status = {ovf_reg, `RSP_STAT_PAD, bits_reg};
    assign rd_next = !bus_i.re                          ? `RSP_BYTE_ZERO :
                     bus_i.addr == `RSP_ADDR_CTRL_A     ? ctrl_a_reg     :
                     bus_i.addr == `RSP_ADDR_CTRL_B     ? ctrl_b_reg     :
                     bus_i.addr == `RSP_ADDR_CAPTURE    ? capt_reg       :
                     bus_i.addr == `RSP_ADDR_DATA       ? data_reg       :
                     bus_i.addr == `RSP_ADDR_STATUS     ? status         :
                                                          `RSP_BYTE_ZERO;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_a_reg <= rsp_ctrl_a_t'(`RSP_CTRL_RESET);
            ctrl_b_reg <= rsp_ctrl_b_t'(`RSP_CTRL_RESET);
        end
        else
        begin
            if (wr_a)
                ctrl_a_reg <= rsp_ctrl_a_t'(bus_i.wdata);
            if (wr_b)
                ctrl_b_reg <= wr_b_val;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pre_reg      <= `RSP_PRE_ZERO;
            sig_prev_reg <= 1'b0;
            rd_data_o    <= `RSP_BYTE_ZERO;
            remote_interrupt_request_o <= 1'b0;
        end
        else
        begin
            pre_reg      <= pre_reg + `RSP_PRE_ONE;
            sig_prev_reg <= sig;
            rd_data_o    <= rd_next;
            remote_interrupt_request_o <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // Width counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= `RSP_BYTE_ZERO;
            run_reg <= 1'b0;
        end
        else if (start_wr || stop_wr)
        begin
            cnt_reg <= `RSP_BYTE_ZERO;
            run_reg <= start_wr;
        end
        else if (!active)
            cnt_reg <= `RSP_BYTE_ZERO;
        else if (cnt_clr)
            cnt_reg <= `RSP_BYTE_ZERO;
        else if (ovf_hit)
        begin
            cnt_reg <= `RSP_BYTE_ZERO;
            run_reg <= 1'b0;
        end
        else if (tick)
            cnt_reg <= cnt_reg + `RSP_CNT_ONE;
    end

    // Overflow flag: a set in the cycle of a restart write wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ovf_reg <= 1'b0;
        else if (ovf_hit)
            ovf_reg <= 1'b1;
        else if (start_wr)
            ovf_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Capture and bit decoder
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            capt_reg <= `RSP_BYTE_ZERO;
            pend_reg <= 1'b0;
        end
        else
        begin
            if (active && meas_end)
                capt_reg <= cnt_reg;
            // Stale decision must not reach the first shift after a restart
            if (start_wr)
                pend_reg <= 1'b0;
            else if (active && recv && fall)
                pend_reg <= bit_val;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            data_reg <= `RSP_BYTE_ZERO;
            bits_reg <= `RSP_BITS_ZERO;
        end
        else if (start_wr)
            bits_reg <= `RSP_BITS_ZERO;
        else if (shift_now)
        begin
            data_reg <= {data_reg[6:0], shift_bit};
            bits_reg <= bits_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_stop_clears_cnt:
    assert property (stop_wr |=> cnt_reg == `RSP_BYTE_ZERO && !run_reg ##1
                     cnt_reg == `RSP_BYTE_ZERO)
        else $error("counter not cleared and held by stop write");

    a_start_clears_ovf:
    assert property (start_wr && !ovf_hit |=> !ovf_reg && run_reg)
        else $error("start write did not clear overflow flag");

    a_ovf_sets_flag:
    assert property (ovf_hit |=> ovf_reg && run_reg == $past(start_wr)
                     && cnt_reg == `RSP_BYTE_ZERO && remote_interrupt_request_o)
        else $error("overflow did not flag, halt and interrupt");

    a_ovf_stays_halted:
    assert property (!run_reg && !start_wr |=> !run_reg)
        else $error("counter resumed without start write");

    a_edge_capture:
    assert property (active && meas_end && !wr_b |=> capt_reg == $past(cnt_reg)
                     && cnt_reg == `RSP_BYTE_ZERO && run_reg)
        else $error("measurement end did not capture and clear");

    a_edge_irq:
    assert property (!recv && edge_end |=> remote_interrupt_request_o)
        else $error("selected edge did not request interrupt");

    a_tick_spacing:
    assert property (tick && ctrl_a_reg.clk_sel == 2'h0 |=> !tick [*8])
        else $error("prescaled tick came too soon");

    a_recv_byte_irq:
    assert property (shift_now && bits_reg == 4'h7 && !start_wr |=>
                     remote_interrupt_request_o && bits_reg == `RSP_BITS_FULL)
        else $error("eighth bit did not interrupt");

    a_bits_reload:
    assert property (shift_now && bits_reg == `RSP_BITS_FULL && !start_wr |=>
                     bits_reg == `RSP_BITS_FIRST && !remote_interrupt_request_o)
        else $error("bit count did not reload to one");

    a_bit_decision:
    assert property (shift_now && ctrl_b_reg.mode == RSP_MODE_CYCLE && !start_wr
                     |=> data_reg[0] == $past(bit_val))
        else $error("decoded bit does not match threshold compare");

endmodule

//--- rsp_ir_source.sv
// Behavioural infrared receiver driving a carrier-free remote waveform
`timescale 1ns/1ps
module rsp_ir_source
(
    input  wire logic clk_i,
    output logic      line_o
);
    // Receiver output idles low between frames
    // Port latch taken as one, so only the receiver sets the pin level
    initial line_o = 1'b0;

    // Holds one level for n clocks; changes just after an edge
    // Short holds model glitches that a scenario asks for
    task automatic drive(input logic lvl, input int n);
        begin
            @(posedge clk_i);
            line_o <= lvl;
            repeat (n - 1) @(posedge clk_i);
        end
    endtask
endmodule

//--- rsp_top_tb.sv
// Self-checking testbench of the remote signal preprocessor
`timescale 1ns/1ps
`include "rsp_regs.svh"
module rsp_top_tb;
    import rsp_pkg::*;

    logic         clk_i;
    logic         rst_n_i;
    rsp_bus_req_t bus;
    logic         pin;
    logic [7:0]   rd_data;
    logic         irq;
    logic [7:0]   exp_q[$];
    logic         rd_pend;
    int           n_errors;
    int           tests_run;
    int           n_irq;
    int           base;
    int           per;
    int           cyc = 0;
    logic [7:0]   ra;
    logic [7:0]   rb;
    logic [6:0]   d;
    logic [1:0]   src;
    logic         pol;

    rsp_top DUT
    (
        .clk_i                      (clk_i),
        .rst_n_i                    (rst_n_i),
        .bus_i                      (bus),
        .remote_signal_input_i      (pin),
        .rd_data_o                  (rd_data),
        .remote_interrupt_request_o (irq)
    );

    rsp_ir_source SRC
    (
        .clk_i  (clk_i),
        .line_o (pin)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // --------------------------------
    // Bus tasks and checks
    // --------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            tests_run++;
            if (got !== exp)
            begin
                n_errors++;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        begin
            @(posedge clk_i);
            bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
            @(posedge clk_i);
            bus.we <= 1'b0;
        end
    endtask

    // Expected data is queued now and compared by the monitor later
    task automatic rd(input logic [11:0] a, input logic [7:0] v);
        begin
            @(posedge clk_i);
            bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
            exp_q.push_back(v);
            @(posedge clk_i);
            bus.re <= 1'b0;
        end
    endtask

    // Free prescaler: start stimulus mid-tick so whole-tick spans count exactly
    task automatic align(input int t);
        begin
            for (int w = 0; w < 4096 && cyc % t != t / 2; w++)
                @(posedge clk_i);
            if (cyc % t != t / 2)
            begin
                n_errors++;
                $display("wrong value at %0t: prescaler phase not found", $time);
            end
        end
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i)
    begin
        if (rd_pend === 1'b1)
            chk(rd_data, exp_q.pop_front());
        if (irq === 1'b1)
            n_irq++;
        if (rst_n_i === 1'b1)
            cyc <= cyc + 1;
        rd_pend <= bus.re;
    end

    task automatic give_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    initial
    begin
        repeat (98000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        bus       = '0;
        rst_n_i   = 1'b0;
        rd_pend   = 1'b0;
        n_errors  = 0;
        tests_run = 0;
        n_irq     = 0;
        void'($urandom(32'h9E43));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;

        rd(`RSP_ADDR_CTRL_A, 8'h00);
        rd(`RSP_ADDR_CTRL_B, 8'h00);
        rd(`RSP_ADDR_CAPTURE, 8'h00);
        rd(`RSP_ADDR_DATA, 8'h00);
        rd(`RSP_ADDR_STATUS, 8'h00);
        wr(`RSP_ADDR_CAPTURE, 8'h5A);
        wr(12'hFED, 8'hA5);
        rd(`RSP_ADDR_CAPTURE, 8'h00);
        rd(12'hFED, 8'h00);
        ra = 8'($urandom);
        rb = 8'($urandom);
        wr(`RSP_ADDR_CTRL_A, ra);
        wr(`RSP_ADDR_CTRL_B, rb);
        rd(`RSP_ADDR_CTRL_A, ra);
        rd(`RSP_ADDR_CTRL_B, rb);
        wr(`RSP_ADDR_CTRL_B, 8'h00);
        wr(`RSP_ADDR_CTRL_A, 8'h00);
        $display("test registers done");

        // Polarity flips make an internal edge, so settle before counting
        for (int i = 0; i < 6; i++)
        begin
            src = 2'(i / 2);
            pol = 1'(i % 2);
            wr(`RSP_ADDR_CTRL_B, {4'h0, 2'b11, 2'(i)});
            wr(`RSP_ADDR_CTRL_A, {2'b00, pol, src, 3'b000});
            repeat (30) @(posedge clk_i);
            base = n_irq;
            SRC.drive(1'b1, 40);
            chk(8'(n_irq - base), 8'((src == 2'b10) || ((src == 2'b00) ^ pol)));
            base = n_irq;
            SRC.drive(1'b0, 40);
            chk(8'(n_irq - base), 8'((src == 2'b10) || ((src == 2'b01) ^ pol)));
        end
        $display("test edge sources done");

        wr(`RSP_ADDR_CTRL_A, 8'h01);
        repeat (100) @(posedge clk_i);
        base = n_irq;
        SRC.drive(1'b1, 20);
        SRC.drive(1'b0, 80);
        chk(8'(n_irq - base), 8'h00);
        SRC.drive(1'b1, 60);
        SRC.drive(1'b0, 80);
        chk(8'(n_irq - base), 8'h01);
        $display("test noise filter done");

        // Whole ticks from a mid-tick start keep the count phase independent
        for (int s = 0; s < 4; s++)
        begin
            per = (64 << (2 * s)) * 3;
            wr(`RSP_ADDR_CTRL_A, 8'(s << 6));
            wr(`RSP_ADDR_CTRL_B, 8'h0C);
            align(64 << (2 * s));
            base = n_irq;
            SRC.drive(1'b1, 10);
            SRC.drive(1'b0, per - 10);
            SRC.drive(1'b1, 10);
            SRC.drive(1'b0, 40);
            rd(`RSP_ADDR_CAPTURE, 8'h03);
            chk(8'(n_irq - base), 8'h02);
        end
        $display("test capture done");

        wr(`RSP_ADDR_CTRL_A, 8'h00);
        wr(`RSP_ADDR_CTRL_B, 8'h04);
        wr(`RSP_ADDR_CTRL_B, 8'h0C);
        base = n_irq;
        repeat (16600) @(posedge clk_i);
        chk(8'(n_irq - base), 8'h01);
        rd(`RSP_ADDR_STATUS, 8'h80);
        repeat (17000) @(posedge clk_i);
        chk(8'(n_irq - base), 8'h01);
        wr(`RSP_ADDR_CTRL_B, 8'h0C);
        rd(`RSP_ADDR_STATUS, 8'h00);
        $display("test overflow done");

        // First edge after start decodes a zero, then seven data bits
        d = 7'($urandom);
        wr(`RSP_ADDR_CTRL_B, 8'h24);
        wr(`RSP_ADDR_CTRL_A, 8'h18);
        wr(`RSP_ADDR_CTRL_B, 8'h2C);
        align(64);
        base = n_irq;
        SRC.drive(1'b1, 10);
        for (int i = 6; i >= 0; i--)
        begin
            per = d[i] ? 2560 : 1280;
            SRC.drive(1'b0, per - 10);
            SRC.drive(1'b1, 10);
        end
        SRC.drive(1'b0, 40);
        chk(8'(n_irq - base), 8'h01);
        rd(`RSP_ADDR_DATA, {1'b0, d});
        rd(`RSP_ADDR_STATUS, 8'h08);
        rd(`RSP_ADDR_CAPTURE, d[0] ? 8'h28 : 8'h14);
        SRC.drive(1'b1, 10);
        SRC.drive(1'b0, 40);
        rd(`RSP_ADDR_STATUS, 8'h01);
        // Width mode: first rise shifts a zero, the high width decides the next
        wr(`RSP_ADDR_CTRL_B, 8'h2D);
        align(64);
        SRC.drive(1'b1, 2560);
        SRC.drive(1'b0, 40);
        rd(`RSP_ADDR_CAPTURE, 8'h28);
        SRC.drive(1'b1, 10);
        SRC.drive(1'b0, 40);
        rd(`RSP_ADDR_DATA, {d[4:0], 3'b001});
        rd(`RSP_ADDR_STATUS, 8'h02);
        $display("test receive done");

        repeat (5) @(posedge clk_i);
        give_verdict();
    end
endmodule
